// ===== sim/usb_ep0_suspend_asserts.sv
`timescale 1ns/1ps
module usb_ep0_chk (
    // apb and bus
    input wire logic pclk, presetn, psel, penable, pwrite, pready, line_idle,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // link and status
    input wire logic rx_err, rx_end, hs_valid, clk_enable, resume_drive,
    input wire logic [1:0] hs_code,
    input wire logic irq_setup, irq_suspend, irq_resume, irq_ext_wake
);
    // figures assume the bench counts: idle 20, wait 30, drive 10
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_drive;
        resume_drive[*8] ##[1:6] !resume_drive;
    endsequence
    chk_susp_idle: assert property ($rose(irq_suspend) |-> $past(line_idle, 8))
        else $error("suspend flagged without idle bus");
    chk_idle_stop: assert property (psel && penable && pready && pwrite && paddr == 12'h008
        && pwdata[0] |=> !clk_enable)
        else $error("clocks still on after idle write");
    chk_wake_clk: assert property ($rose(clk_enable) |-> irq_resume || irq_ext_wake)
        else $error("clocks back without wake cause");
    chk_drive_len: assert property ($rose(resume_drive) |-> s_drive)
        else $error("resume drive length wrong");
    chk_drive_wait: assert property ($rose(resume_drive) |-> $past(line_idle, 40))
        else $error("resume drive too early");
    chk_setup_ack: assert property ($rose(irq_setup) |-> hs_valid && hs_code == 2'h0)
        else $error("setup flag without ack");
    chk_setup_nak: assert property (hs_valid && $past(irq_setup) && irq_setup
        |-> hs_code == 2'h1)
        else $error("no nak while setup pending");
    chk_err_quiet: assert property (rx_err && rx_end |=> !hs_valid)
        else $error("handshake after bad packet");
endmodule // usb_ep0_chk
bind usb_ep0_suspend usb_ep0_chk chk (.*);

// ===== sim/usb_ep0_suspend_tb.sv
`timescale 1ns/1ps
`include "usb_ep0_cfg.svh"
module usb_ep0_suspend_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xwake = 0, err, nul;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, resume_drive, clk_enable, hs_valid, tx_valid, tx_last, tx_null;
    logic tok_valid, rx_valid, rx_data1, rx_err, rx_end, line_idle, tx_ready, host_ack;
    logic host_timeout, tx_data1;
    logic [3:0] tok_ep = 4'h0;
    logic [1:0] tok_pid, hs_code, hs;
    logic [7:0] rx_data, tx_data;
    logic [5:0] irq;
    int fails = 0, checked = 0, cyc = 0, cnt;
    always #12.5 pclk = ~pclk;
    usb_ep0_suspend #(.SUSP_IDLE_CYC(20), .RWU_WAIT_CYC(30), .RWU_DRIVE_CYC(10)) dut (.*,
        .external_wake_interrupt(xwake),
        .irq_setup(irq[0]), .irq_suspend(irq[1]), .irq_resume(irq[2]),
        .irq_ext_wake(irq[3]), .irq_out0(irq[4]), .irq_in0(irq[5]));
    usb_host_model host (.*);
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `REG_OUT0_CFG, 0);
        chk("out0 reset", rd, `EP_CFG_RESET);
        host.pkt(0, 1, 1, 0, hs);
        chk("ep off", hs, 2'h3);
        apb(1, `REG_OUT0_CFG, 32'h0808_0019);
        apb(1, `REG_IN0_CFG, 32'h0810_0018);
        apb(0, 12'h040, 0);
        chk("unmapped", {rd[30:0], err}, 1);
        host.pkt(2'h2, 8, 0, 0, hs);
        chk("setup hs", hs, usb_ep0_pkg::HS_ACK);
        apb(0, `REG_BUF_BASE, 0);
        chk("setup byte", rd[7:0], 8'hA0);
        host.pkt(0, 2, 1, 0, hs);
        chk("setup nak", hs, usb_ep0_pkg::HS_NAK);
        apb(1, `REG_USB_STATUS, 1);
        @(posedge pclk);
        chk("setup clr", irq[0], 0);
        $display("test setup done");
        host.pkt(0, 3, 1, 0, hs);
        chk("out hs", hs, usb_ep0_pkg::HS_ACK);
        chk("out irq", irq[4], 1);
        apb(0, `REG_OUT0_CFG, 0);
        chk("out cfg", rd, 32'h0808_031C);
        apb(0, `REG_BUF_BASE + 12'h020, 0);
        chk("out byte", rd[7:0], 8'hA0);
        host.pkt(0, 1, 0, 0, hs);
        chk("out held", hs, usb_ep0_pkg::HS_NAK);
        tok_ep <= 4'h1;
        host.pkt(0, 1, 1, 0, hs);
        chk("other ep", hs, 2'h3);
        tok_ep <= 4'h0;
        apb(1, `REG_OUT0_CFG, 32'h0808_0018);
        host.pkt(0, 2, 0, 1, hs);
        chk("out crc", hs, 2'h3);
        apb(1, `REG_IN0_CFG, 32'h0810_0019);
        host.in_tok(0, hs, nul);
        chk("no ack", irq[5], 0);
        host.in_tok(1, hs, nul);
        chk("null pkt", {irq[5], nul}, 2'h3);
        apb(0, `REG_IN0_CFG, 0);
        chk("in cfg", rd, 32'h0810_001C);
        host.in_tok(1, hs, nul);
        chk("in held", hs, usb_ep0_pkg::HS_NAK);
        apb(1, `REG_BUF_BASE + 12'h040, 32'h0000_005A);
        apb(1, `REG_BUF_BASE + 12'h044, 32'h0000_00C3);
        apb(1, `REG_IN0_CFG, 32'h0810_0218);
        host.in_tok(1, hs, nul);
        chk("in data", host.tx_seen, 8'hC3);
        apb(1, `REG_OUT0_CFG, 32'h0808_001A);
        apb(1, `REG_IN0_CFG, 32'h0810_001A);
        host.pkt(0, 1, 1, 0, hs);
        chk("out stall", hs, usb_ep0_pkg::HS_STALL);
        host.in_tok(1, hs, nul);
        chk("in stall", hs, usb_ep0_pkg::HS_STALL);
        $display("test transfer done");
        host.line_idle <= 1'b1;
        repeat (40) @(posedge pclk);
        chk("suspend irq", irq[1], 1);
        apb(1, `REG_USB_CTRL, 1);
        apb(1, `REG_POWER_CTRL, 1);
        @(posedge pclk);
        chk("clk off", clk_enable, 0);
        cnt = 0;
        repeat (80) @(posedge pclk) cnt += resume_drive;
        chk("drive len", cnt, 10);
        host.line_idle <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("resume", {clk_enable, irq[2]}, 2'h3);
        apb(0, `REG_POWER_CTRL, 0);
        chk("idle clr", rd[0], 0);
        apb(1, `REG_USB_STATUS, 32'h0000_003F);
        apb(1, `REG_POWER_CTRL, 1);
        xwake <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("ext wake", {clk_enable, irq[3]}, 2'h3);
        $display("test power done");
        wrap_up;
    end
endmodule // usb_ep0_suspend_tb

// ===== sim/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
    // device answers
    input wire logic pclk, hs_valid, tx_valid, tx_last, tx_null, tx_data1,
    input wire logic [7:0] tx_data,
    input wire logic [1:0] hs_code,
    // host traffic
    output logic tok_valid, rx_valid, rx_data1, rx_err, rx_end, tx_ready, host_ack,
    output logic host_timeout, line_idle,
    output logic [1:0] tok_pid,
    output logic [7:0] rx_data
);
    logic [7:0] tx_seen;
    initial {tok_valid, rx_valid, rx_data1, rx_err, rx_end, tx_ready, host_ack} = 7'h00;
    initial {host_timeout, line_idle, tok_pid, rx_data} = 12'h05A;
    task automatic token(input logic [1:0] pid);
        @(posedge pclk);
        tok_valid <= 1'b1;
        tok_pid <= pid;
        @(posedge pclk);
        tok_valid <= 1'b0;
    endtask
    task automatic pkt(input logic [1:0] pid, input int n, input logic d1, e,
                       output logic [1:0] hs);
        token(pid);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= 8'hA0 + 8'(i);
            @(posedge pclk);
        end
        {rx_valid, rx_end, rx_err} <= {1'b0, 1'b1, e};
        rx_data1 <= d1;
        @(posedge pclk);
        {rx_end, rx_err} <= 2'h0;
        // released data line must not keep the last byte
        rx_data <= ~rx_data;
        @(posedge pclk);
        hs = hs_valid ? hs_code : 2'h3;
    endtask
    task automatic in_tok(input logic ack, output logic [1:0] hs, output logic nul);
        hs = 2'h3;
        nul = 1'b0;
        token(2'h1);
        repeat (16) begin
            @(posedge pclk);
            // ready toggles each cycle, in step with the two-cycle beat, so no beat meets a stall
            tx_ready <= ~tx_ready;
            if (hs_valid) hs = hs_code;
            if (tx_valid && tx_ready) tx_seen = tx_data;
            if (tx_valid && tx_ready && tx_last) begin
                nul = tx_null && tx_data1;
                {host_ack, host_timeout} <= {ack, !ack};
                @(posedge pclk);
                {host_ack, host_timeout} <= 2'h0;
            end
        end
    endtask
endmodule // usb_host_model

// ===== src/ep0_buffer_mem.sv
`timescale 1ns/1ps

module ep0_buffer_mem (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    // read port, data registered
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:31];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule // ep0_buffer_mem

// ===== src/usb_ep0_cfg.svh
`ifndef USB_EP0_CFG_SVH
`define USB_EP0_CFG_SVH

// register byte offsets
`define REG_USB_CTRL 12'h000
`define REG_USB_STATUS 12'h004
`define REG_POWER_CTRL 12'h008
`define REG_OUT0_CFG 12'h00C
`define REG_IN0_CFG 12'h010
`define REG_BUF_BASE 12'h080
`define REG_BUF_LAST 12'h0FC

// usb control fields
`define CTRL_REMOTE_WAKE 0
`define CTRL_SUSPENDED 1
`define CTRL_RESUME_DRIVE 2

// usb status fields, write one to clear
`define STA_SETUP 0
`define STA_SUSPEND_REQ 1
`define STA_RESUME_REQ 2
`define STA_EXT_WAKE 3
`define STA_OUT0 4
`define STA_IN0 5

// power control
`define POWER_CONTROL_REGISTER_IDLE_MODE 0

// endpoint-0 configuration word fields
`define EP_TOGGLE 0
`define EP_STALL 1
`define EP_NAK_HOLD 2
`define EP_ENABLE 3
`define EP_INT_EN 4
`define EP_COUNT_LSB 8
`define EP_BASE_LSB 16
`define EP_SIZE_LSB 24
`define EP_CFG_RESET 32'h0000_0000
`define EP_CFG_WMASK 32'h3F1F_001F

// endpoint numbering
`define EP_LAST_NUM 4'h7
`define SETUP_BYTES 6'h08

// timing
`define CLK_PERIOD_NS 25
`define SUSP_IDLE_NS 3000000
`define RWU_WAIT_NS 5000000
`define RWU_DRIVE_MIN_NS 1000000
`define RWU_DRIVE_MAX_NS 15000000
`define SUSP_IDLE_CYC ((`SUSP_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RWU_WAIT_CYC ((`RWU_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RWU_DRIVE_CYC ((`RWU_DRIVE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RWU_DRIVE_MAX_CYC (`RWU_DRIVE_MAX_NS / `CLK_PERIOD_NS)

`endif

// ===== src/usb_ep0_pkg.sv
package usb_ep0_pkg;

    typedef enum logic [1:0] {
        TOK_OUT = 2'b00,
        TOK_IN = 2'b01,
        TOK_SETUP = 2'b10,
        TOK_RSVD = 2'b11
    } token_e;

    typedef enum logic [1:0] {
        HS_ACK = 2'b00,
        HS_NAK = 2'b01,
        HS_STALL = 2'b10,
        HS_NONE = 2'b11
    } handshake_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP_RX = 3'b001,
        ST_OUT_RX = 3'b010,
        ST_TX_LOAD = 3'b011,
        ST_TX = 3'b100,
        ST_TX_WAIT = 3'b101
    } ep0_state_e;

endpackage

// ===== src/usb_ep0_suspend.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "usb_ep0_cfg.svh"

module usb_ep0_suspend #(
    parameter int SUSP_IDLE_CYC = `SUSP_IDLE_CYC,
    parameter int RWU_WAIT_CYC = `RWU_WAIT_CYC,
    parameter int RWU_DRIVE_CYC = `RWU_DRIVE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus pins
    input wire logic line_idle,
    input wire logic external_wake_interrupt,
    output logic resume_drive,
    // serial engine side, same clock
    input wire logic tok_valid,
    input wire logic [1:0] tok_pid,
    input wire logic [3:0] tok_ep,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_data1,
    input wire logic rx_err,
    input wire logic rx_end,
    output logic hs_valid,
    output logic [1:0] hs_code,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_null,
    output logic tx_data1,
    input wire logic tx_ready,
    input wire logic host_ack,
    input wire logic host_timeout,
    // microcontroller side
    output logic clk_enable,
    output logic irq_setup,
    output logic irq_suspend,
    output logic irq_resume,
    output logic irq_ext_wake,
    output logic irq_out0,
    output logic irq_in0
);

    logic idle_s1, idle_s2, wake_s1, wake_s2, wake_s3;
    logic [19:0] idle_cnt_reg, susp_time_reg, drive_cnt_reg;
    logic suspended_reg, idle_mode_bit, remote_wake_request_bit;
    logic setup_flag, suspend_request_flag, resume_request_flag, ext_flag;
    logic out_flag, in_flag, buf_ph_reg;
    logic [31:0] out_cfg_reg, in_cfg_reg;
    usb_ep0_pkg::ep0_state_e state_reg;
    logic [5:0] ptr_reg;
    logic [7:0] cnt_reg;
    usb_ep0_pkg::handshake_e resp_reg;
    logic store_reg, err_reg;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic [4:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata;

    logic acc, wr, is_buf, usb_busy, apb_own, buf_done, mapped;
    logic wr_status, wr_out, wr_in, rx_wr, tok0, now_idle, wake_edge, resume_seen;
    logic [4:0] out_base, in_base;
    logic [7:0] in_count;

    assign acc = psel && penable;
    assign is_buf = (paddr >= `REG_BUF_BASE) && (paddr <= `REG_BUF_LAST);
    assign usb_busy = (state_reg != usb_ep0_pkg::ST_IDLE)
                      && (state_reg != usb_ep0_pkg::ST_TX_WAIT);
    // the memory port belongs to the usb side during a packet, so software waits
    assign apb_own = acc && is_buf && !usb_busy;
    assign buf_done = buf_ph_reg && apb_own;
    assign pready = !(acc && is_buf) || buf_done;
    assign wr = acc && pwrite && pready;
    assign wr_status = wr && (paddr == `REG_USB_STATUS);
    assign wr_out = wr && (paddr == `REG_OUT0_CFG);
    assign wr_in = wr && (paddr == `REG_IN0_CFG);
    assign mapped = is_buf || (paddr == `REG_USB_CTRL) || (paddr == `REG_USB_STATUS)
                    || (paddr == `REG_POWER_CTRL) || (paddr == `REG_OUT0_CFG)
                    || (paddr == `REG_IN0_CFG);
    assign pslverr = acc && pready && !mapped;
    assign out_base = out_cfg_reg[`EP_BASE_LSB +: 5];
    assign in_base = in_cfg_reg[`EP_BASE_LSB +: 5];
    assign in_count = in_cfg_reg[`EP_COUNT_LSB +: 8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_ph_reg <= 1'b0;
        end else begin
            buf_ph_reg <= apb_own && !buf_done;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (1'b1)
            is_buf: prdata = {24'h00_0000, mem_rdata};
            paddr == `REG_USB_CTRL: prdata = {29'h0000_0000, resume_drive, suspended_reg,
                                              remote_wake_request_bit};
            paddr == `REG_USB_STATUS: prdata = {26'h000_0000, in_flag, out_flag, ext_flag,
                                                resume_request_flag, suspend_request_flag,
                                                setup_flag};
            paddr == `REG_POWER_CTRL: prdata = {31'h0000_0000, idle_mode_bit};
            paddr == `REG_OUT0_CFG: prdata = out_cfg_reg;
            paddr == `REG_IN0_CFG: prdata = in_cfg_reg;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // pins from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_s1 <= 1'b1;
            idle_s2 <= 1'b1;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            idle_s1 <= line_idle;
            idle_s2 <= idle_s1;
            wake_s1 <= external_wake_interrupt;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end

    // pclk stays free running here; only clk_enable gates the rest of the device
    assign now_idle = idle_s2 || resume_drive;
    assign wake_edge = wake_s2 && !wake_s3;
    assign resume_seen = suspended_reg && !now_idle;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_reg <= 20'h0_0000;
            suspended_reg <= 1'b0;
            susp_time_reg <= 20'h0_0000;
        end else begin
            if (!now_idle) begin
                idle_cnt_reg <= 20'h0_0000;
            end else if (idle_cnt_reg <= 20'(SUSP_IDLE_CYC)) begin
                idle_cnt_reg <= idle_cnt_reg + 20'h0_0001;
            end
            if (resume_seen) begin
                suspended_reg <= 1'b0;
            end else if (idle_cnt_reg == 20'(SUSP_IDLE_CYC)) begin
                suspended_reg <= 1'b1;
            end
            if (!suspended_reg) begin
                susp_time_reg <= 20'h0_0000;
            end else if (susp_time_reg < 20'(RWU_WAIT_CYC)) begin
                susp_time_reg <= susp_time_reg + 20'h0_0001;
            end
        end
    end

    // remote wake: hold off until 5 ms of suspend, then drive a fixed span
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_wake_request_bit <= 1'b0;
            resume_drive <= 1'b0;
            drive_cnt_reg <= 20'h0_0000;
        end else begin
            if (resume_drive) begin
                drive_cnt_reg <= drive_cnt_reg + 20'h0_0001;
                if (drive_cnt_reg == 20'(RWU_DRIVE_CYC - 1)) begin
                    resume_drive <= 1'b0;
                    remote_wake_request_bit <= 1'b0;
                end
            end else if (remote_wake_request_bit && suspended_reg
                         && susp_time_reg == 20'(RWU_WAIT_CYC)) begin
                resume_drive <= 1'b1;
                drive_cnt_reg <= 20'h0_0000;
            end
            if (wr && paddr == `REG_USB_CTRL && !resume_drive) begin
                remote_wake_request_bit <= pwdata[`CTRL_REMOTE_WAKE];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_mode_bit <= 1'b0;
        end else if (resume_seen || (wake_edge && idle_mode_bit)) begin
            idle_mode_bit <= 1'b0;
        end else if (wr && paddr == `REG_POWER_CTRL) begin
            idle_mode_bit <= pwdata[`POWER_CONTROL_REGISTER_IDLE_MODE];
        end
    end

    // gated from the register, so the write itself still completes
    assign clk_enable = !idle_mode_bit;

    // sticky status flags: a hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_request_flag <= 1'b0;
            resume_request_flag <= 1'b0;
            ext_flag <= 1'b0;
        end else begin
            if (suspended_reg == 1'b0 && idle_cnt_reg == 20'(SUSP_IDLE_CYC)) begin
                suspend_request_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_SUSPEND_REQ]) begin
                suspend_request_flag <= 1'b0;
            end
            if (resume_seen) begin
                resume_request_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_RESUME_REQ]) begin
                resume_request_flag <= 1'b0;
            end
            if (wake_edge && idle_mode_bit) begin
                ext_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_EXT_WAKE]) begin
                ext_flag <= 1'b0;
            end
        end
    end

    assign irq_suspend = suspend_request_flag;
    assign irq_resume = resume_request_flag;
    assign irq_ext_wake = ext_flag;
    assign irq_setup = setup_flag;
    assign irq_out0 = out_flag && out_cfg_reg[`EP_INT_EN];
    assign irq_in0 = in_flag && in_cfg_reg[`EP_INT_EN];

    // endpoint zero control transfer engine; other endpoints are served elsewhere
    assign tok0 = tok_valid && (tok_ep == 4'h0);
    assign rx_wr = rx_valid && store_reg && (state_reg == usb_ep0_pkg::ST_SETUP_RX
                   ? ptr_reg < `SETUP_BYTES
                   : (state_reg == usb_ep0_pkg::ST_OUT_RX
                      && ptr_reg < out_cfg_reg[`EP_SIZE_LSB +: 6]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= usb_ep0_pkg::ST_IDLE;
            ptr_reg <= 6'h00;
            resp_reg <= usb_ep0_pkg::HS_NONE;
            store_reg <= 1'b0;
            err_reg <= 1'b0;
            hs_valid <= 1'b0;
            hs_code <= 2'b11;
        end else begin
            hs_valid <= 1'b0;
            unique case (state_reg)
                usb_ep0_pkg::ST_IDLE: begin
                    ptr_reg <= 6'h00;
                    err_reg <= 1'b0;
                    if (tok0 && tok_pid == usb_ep0_pkg::TOK_SETUP) begin
                        state_reg <= usb_ep0_pkg::ST_SETUP_RX;
                        store_reg <= 1'b1;
                        resp_reg <= usb_ep0_pkg::HS_ACK;
                    end else if (tok0 && tok_pid == usb_ep0_pkg::TOK_OUT
                                 && out_cfg_reg[`EP_ENABLE]) begin
                        state_reg <= usb_ep0_pkg::ST_OUT_RX;
                        store_reg <= 1'b0;
                        if (setup_flag) begin
                            resp_reg <= usb_ep0_pkg::HS_NAK;
                        end else if (out_cfg_reg[`EP_STALL]) begin
                            resp_reg <= usb_ep0_pkg::HS_STALL;
                        end else if (out_cfg_reg[`EP_NAK_HOLD]) begin
                            resp_reg <= usb_ep0_pkg::HS_NAK;
                        end else begin
                            resp_reg <= usb_ep0_pkg::HS_ACK;
                            store_reg <= 1'b1;
                        end
                    end else if (tok0 && tok_pid == usb_ep0_pkg::TOK_IN
                                 && in_cfg_reg[`EP_ENABLE]) begin
                        if (setup_flag) begin
                            hs_valid <= 1'b1;
                            hs_code <= usb_ep0_pkg::HS_NAK;
                        end else if (in_cfg_reg[`EP_STALL]) begin
                            hs_valid <= 1'b1;
                            hs_code <= usb_ep0_pkg::HS_STALL;
                        end else if (in_cfg_reg[`EP_NAK_HOLD]) begin
                            hs_valid <= 1'b1;
                            hs_code <= usb_ep0_pkg::HS_NAK;
                        end else begin
                            state_reg <= usb_ep0_pkg::ST_TX_LOAD;
                        end
                    end
                end
                usb_ep0_pkg::ST_SETUP_RX, usb_ep0_pkg::ST_OUT_RX: begin
                    if (rx_valid) begin
                        ptr_reg <= ptr_reg + 6'h01;
                    end
                    if (rx_err) begin
                        err_reg <= 1'b1;
                    end
                    if (rx_end) begin
                        state_reg <= usb_ep0_pkg::ST_IDLE;
                        // corrupted packets get no handshake at all
                        hs_valid <= !(err_reg || rx_err);
                        hs_code <= resp_reg;
                    end
                end
                usb_ep0_pkg::ST_TX_LOAD: begin
                    state_reg <= usb_ep0_pkg::ST_TX;
                end
                usb_ep0_pkg::ST_TX: begin
                    if (tx_ready) begin
                        ptr_reg <= ptr_reg + 6'h01;
                        state_reg <= tx_last ? usb_ep0_pkg::ST_TX_WAIT
                                             : usb_ep0_pkg::ST_TX_LOAD;
                    end
                end
                usb_ep0_pkg::ST_TX_WAIT: begin
                    // no answer leaves count and toggle alone, so the packet repeats
                    if (host_ack || host_timeout) begin
                        state_reg <= usb_ep0_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= usb_ep0_pkg::ST_IDLE;
            endcase
        end
    end

    assign tx_valid = (state_reg == usb_ep0_pkg::ST_TX);
    assign tx_null = (in_count == 8'h00);
    assign tx_last = tx_null || ({2'b00, ptr_reg} == in_count - 8'h01);
    assign tx_data1 = in_cfg_reg[`EP_TOGGLE];

    // taken from the memory's output register: the address stands through TX_LOAD
    // and TX, so the byte is settled when the beat starts; a copy would lag a byte
    assign tx_data = mem_rdata;

    // a packet whose toggle does not match is still stored and acked, but not counted or flagged
    logic out_done;
    assign out_done = state_reg == usb_ep0_pkg::ST_OUT_RX && rx_end && !err_reg && !rx_err
                      && store_reg && (rx_data1 == out_cfg_reg[`EP_TOGGLE]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (state_reg == usb_ep0_pkg::ST_IDLE) begin
            cnt_reg <= 8'h00;
        end else if (rx_wr) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_cfg_reg <= `EP_CFG_RESET;
        end else begin
            if (wr_out) begin
                out_cfg_reg <= (pwdata & `EP_CFG_WMASK)
                               | {16'h0000, out_cfg_reg[15:8], 8'h00};
            end
            if (out_done) begin
                out_cfg_reg[`EP_COUNT_LSB +: 8] <= cnt_reg;
                out_cfg_reg[`EP_TOGGLE] <= !out_cfg_reg[`EP_TOGGLE];
                out_cfg_reg[`EP_NAK_HOLD] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_cfg_reg <= `EP_CFG_RESET;
        end else begin
            if (wr_in) begin
                in_cfg_reg <= pwdata & (`EP_CFG_WMASK | 32'h0000_FF00);
            end
            if (state_reg == usb_ep0_pkg::ST_TX_WAIT && host_ack) begin
                in_cfg_reg[`EP_TOGGLE] <= !in_cfg_reg[`EP_TOGGLE];
                in_cfg_reg[`EP_NAK_HOLD] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_flag <= 1'b0;
            out_flag <= 1'b0;
            in_flag <= 1'b0;
        end else begin
            if (state_reg == usb_ep0_pkg::ST_SETUP_RX && rx_end && !err_reg && !rx_err) begin
                setup_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_SETUP]) begin
                setup_flag <= 1'b0;
            end
            if (out_done) begin
                out_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_OUT0]) begin
                out_flag <= 1'b0;
            end
            if (state_reg == usb_ep0_pkg::ST_TX_WAIT && host_ack) begin
                in_flag <= 1'b1;
            end else if (wr_status && pwdata[`STA_IN0]) begin
                in_flag <= 1'b0;
            end
        end
    end

    // setup bytes land at words 0..7; out data lands at the programmed base
    always_comb begin
        mem_we = rx_wr || (buf_done && pwrite);
        mem_waddr = paddr[6:2];
        mem_wdata = pwdata[7:0];
        if (rx_wr) begin
            mem_wdata = rx_data;
            mem_waddr = (state_reg == usb_ep0_pkg::ST_SETUP_RX) ? ptr_reg[4:0]
                                                                 : out_base + ptr_reg[4:0];
        end
        mem_raddr = usb_busy ? in_base + ptr_reg[4:0] : paddr[6:2];
    end

    ep0_buffer_mem u_mem (
        .clk(pclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

endmodule // usb_ep0_suspend
